/* ssp_cfg.svh */
// Offsets, field positions, reset values and rate counts of the serial port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_CTRL_ADDR 8'hf8
`define SSP_BIT_ADDR_MASK 8'hf8
`define SSP_CTRL_RESET 8'h00
`define SSP_FE_RESET 1'h0
`define SSP_BIT_MODE_HI 3'h7
`define SSP_BIT_MODE_LO 3'h6
`define SSP_MODE0_HALF_CYCLES 8'h06
`define SSP_MODE2_TICK_CYCLES 8'h04
`define SSP_OVERSAMPLE_LAST 4'hf
`define SSP_START_MID 4'h7
`define SSP_M0_LAST_BIT 4'h7
`define SSP_STOP_IDX8 4'h9
`define SSP_STOP_IDX9 4'ha
`define SSP_LAST_DATA8 4'h7
`define SSP_LAST_DATA9 4'h8
`endif

/* ssp_pkg.sv */
// Types shared by the serial port control logic
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_MODE_SHIFT = 2'h0,
    SSP_MODE_UART8 = 2'h1,
    SSP_MODE_FIXED9 = 2'h2,
    SSP_MODE_VAR9 = 2'h3
  } ssp_mode_t;
  typedef struct packed {
    logic mode_hi_or_frame_err;
    logic mode_lo_bit;
    logic multiproc_filter_en;
    logic rx_enable;
    logic ninth_tx_bit;
    logic ninth_rx_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } ssp_ctrl_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic bit_op;
    logic [7:0] wdata;
  } ssp_sfr_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic ninth;
    logic stop;
  } ssp_rx_frame_t;
  function automatic logic ssp_is_nine(input ssp_mode_t m);
    return m[1];
  endfunction
endpackage

/* ssp_tx.sv */
// Transmit shifter for the four serial modes
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_tx (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Mode and rate
  input wire ssp_pkg::ssp_mode_t i_mode,
  input wire logic i_tick16,
  input wire logic i_shift_tick,
  // Frame request
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic i_ninth,
  // Line side
  output logic o_busy,
  output logic o_ser,
  output logic o_sclk,
  output logic o_done
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SHIFT = 2'h1,
    TX_STOP = 2'h3
  } ssp_tx_state_t;
  ssp_tx_state_t st_reg, st_next;
  logic [10:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next, sub_reg, sub_next, stop_idx;
  logic sclk_reg, sclk_next, done_reg, done_next, m0, nine;
  assign m0 = (i_mode == ssp_pkg::SSP_MODE_SHIFT);
  assign nine = ssp_pkg::ssp_is_nine(i_mode);
  assign stop_idx = nine ? `SSP_STOP_IDX9 : `SSP_STOP_IDX8;
  always_comb
  begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    sub_next = sub_reg;
    sclk_next = sclk_reg;
    done_next = 1'b0;
    unique case (st_reg)
      TX_IDLE:
      begin
        sclk_next = 1'b1;
        cnt_next = 4'h0;
        sub_next = 4'h0;
        if (i_start)
        begin
          st_next = TX_SHIFT;
          if (m0)
            sh_next = {3'h7, i_data};
          else
            sh_next = {1'b1, nine ? i_ninth : 1'b1, i_data, 1'b0};
        end
      end
      TX_SHIFT:
      begin
        if (m0 && i_shift_tick)
        begin
          sclk_next = ~sclk_reg;
          if (!sclk_reg)
          begin
            sh_next = {1'b1, sh_reg[10:1]};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `SSP_M0_LAST_BIT)
            begin
              st_next = TX_IDLE;
              done_next = 1'b1;
            end
          end
        end
        else if (!m0 && i_tick16)
        begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == `SSP_OVERSAMPLE_LAST)
          begin
            sh_next = {1'b1, sh_reg[10:1]};
            cnt_next = cnt_reg + 4'h1;
            // Flag rises as the stop bit starts, after the last data bit
            if (cnt_next == stop_idx)
            begin
              st_next = TX_STOP;
              done_next = 1'b1;
            end
          end
        end
      end
      TX_STOP:
      begin
        if (i_tick16)
        begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == `SSP_OVERSAMPLE_LAST)
            st_next = TX_IDLE;
        end
      end
      default: st_next = TX_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= TX_IDLE;
      sh_reg <= 11'h7ff;
      cnt_reg <= 4'h0;
      sub_reg <= 4'h0;
      sclk_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      sub_reg <= sub_next;
      sclk_reg <= sclk_next;
      done_reg <= done_next;
    end
  end
  assign o_busy = (st_reg != TX_IDLE);
  assign o_ser = sh_reg[0];
  assign o_sclk = sclk_reg;
  assign o_done = done_reg;
endmodule

/* ssp_rx.sv */
// Receive shifter for the four serial modes
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_rx (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Mode and rate
  input wire ssp_pkg::ssp_mode_t i_mode,
  input wire logic i_tick16,
  input wire logic i_shift_tick,
  // Control
  input wire logic i_enable,
  input wire logic i_shift_start,
  input wire logic i_rxd,
  // Results
  output ssp_pkg::ssp_rx_frame_t o_frame,
  output logic o_busy,
  output logic o_sclk
);
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } ssp_rx_state_t;
  ssp_rx_state_t st_reg, st_next;
  ssp_pkg::ssp_rx_frame_t fr_reg, fr_next;
  logic [7:0] data_reg, data_next;
  logic [3:0] cnt_reg, cnt_next, sub_reg, sub_next;
  logic ninth_reg, ninth_next, sclk_reg, sclk_next, m0, nine;
  assign m0 = (i_mode == ssp_pkg::SSP_MODE_SHIFT);
  assign nine = ssp_pkg::ssp_is_nine(i_mode);
  always_comb
  begin
    st_next = st_reg;
    fr_next = fr_reg;
    fr_next.valid = 1'b0;
    data_next = data_reg;
    cnt_next = cnt_reg;
    sub_next = sub_reg;
    ninth_next = ninth_reg;
    sclk_next = sclk_reg;
    unique case (st_reg)
      RX_IDLE:
      begin
        sclk_next = 1'b1;
        cnt_next = 4'h0;
        sub_next = 4'h0;
        if (m0)
        begin
          if (i_shift_start)
            st_next = RX_DATA;
        end
        else if (i_enable && i_tick16 && !i_rxd)
          st_next = RX_START;
      end
      RX_START:
      begin
        if (i_tick16)
        begin
          sub_next = sub_reg + 4'h1;
          // Half-bit recheck drops glitches shorter than half a bit
          if (sub_reg == `SSP_START_MID)
          begin
            sub_next = 4'h0;
            st_next = i_rxd ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (m0 && i_shift_tick)
        begin
          sclk_next = ~sclk_reg;
          if (!sclk_reg)
          begin
            data_next = {i_rxd, data_reg[7:1]};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `SSP_M0_LAST_BIT)
            begin
              st_next = RX_IDLE;
              fr_next = {1'b1, data_next, 1'b1, 1'b1};
            end
          end
        end
        else if (!m0 && i_tick16)
        begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == `SSP_OVERSAMPLE_LAST)
          begin
            if (cnt_reg < 4'h8)
              data_next = {i_rxd, data_reg[7:1]};
            else
              ninth_next = i_rxd;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == (nine ? `SSP_LAST_DATA9 : `SSP_LAST_DATA8))
              st_next = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (i_tick16)
        begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == `SSP_OVERSAMPLE_LAST)
          begin
            st_next = RX_IDLE;
            // Stop level stands in for the ninth bit in 8-bit mode
            fr_next = {1'b1, data_reg, nine ? ninth_reg : i_rxd, i_rxd};
          end
        end
      end
    endcase
    if (!i_enable)
    begin
      st_next = RX_IDLE;
      sclk_next = 1'b1;
      fr_next.valid = 1'b0;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= RX_IDLE;
      fr_reg <= '0;
      data_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sub_reg <= 4'h0;
      ninth_reg <= 1'b0;
      sclk_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      fr_reg <= fr_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
      sub_reg <= sub_next;
      ninth_reg <= ninth_next;
      sclk_reg <= sclk_next;
    end
  end
  assign o_frame = fr_reg;
  assign o_busy = (st_reg != RX_IDLE);
  assign o_sclk = sclk_reg;
endmodule

/* ssp_port.sv */
// Serial port control register, flags, reception filter and pin muxing
`timescale 1ns/1ps
`include "ssp_cfg.svh"
// Functional notes
// - Alternate view: bit seven is sticky frame error
// - Shift mode ignores multiprocessor filter
// - 8-bit mode filter: stop high and address
// - 9-bit modes filter: ninth high and address
// - No reception while receive enable low
// - Shift receive starts on enable, flag clear
// - Ninth transmit bit sent only in 9-bit
// - Ninth received bit, or stop in 8-bit
// - Transmit flag set after last data bit, sticky
// - Receive flag set at frame end, filtered
// - Either flag requests interrupt when enabled
// - Register bits reachable by bit or byte
module ssp_port (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register access
  input wire ssp_pkg::ssp_sfr_req_t i_sfr_req,
  output logic [7:0] o_sfr_rdata,
  // Configuration from neighbouring logic
  input wire logic i_flag_view_select,
  input wire logic i_port_int_en,
  input wire logic i_baud_tick16,
  input wire logic [7:0] i_given_addr,
  input wire logic [7:0] i_bcast_addr,
  // Transmit data
  input wire logic i_tx_load,
  input wire logic [7:0] i_tx_data,
  // Received data
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  // Serial pins
  input wire logic i_rxd,
  output logic o_rxd,
  output logic o_rxd_oe,
  output logic o_txd,
  // Interrupt request
  output logic o_serial_irq
);
  logic rst_meta_reg, rst_sync_n_reg, rst_n;
  logic rxd_meta_reg, rxd_sync_reg;
  logic [7:0] m0_cnt_reg, m0_cnt_next, m2_cnt_reg, m2_cnt_next;
  logic shift_tick_reg, shift_tick_next, m2_tick_reg, m2_tick_next;
  ssp_pkg::ssp_ctrl_t ctrl_reg, ctrl_next;
  logic fe_reg, fe_next;
  logic [7:0] view, wmask, wval, upd;
  ssp_pkg::ssp_mode_t mode;
  logic m0, tick16, addr_match, rx_accept, frame_err;
  logic tx_start, tx_busy, tx_ser, tx_sclk, tx_done;
  logic rx_busy, rx_sclk, shift_start;
  ssp_pkg::ssp_rx_frame_t frame;
  logic [7:0] rdata_reg, rdata_next, rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next, irq_reg, irq_next;
  logic txd_reg, txd_next, rxd_out_reg, rxd_out_next;
  logic rxd_oe_reg, rxd_oe_next;

  // Byte hit or one-hot bit hit for a register access
  function automatic logic [7:0] sfr_mask(input logic [7:0] addr,
                                          input logic bit_op);
    logic [7:0] m;
    m = 8'h00;
    if (bit_op)
    begin
      if ((addr & `SSP_BIT_ADDR_MASK) == `SSP_CTRL_ADDR)
        m = 8'h01 << addr[2:0];
    end
    else if (addr == `SSP_CTRL_ADDR)
      m = 8'hff;
    return m;
  endfunction

  // Reset release through two stages
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_n_reg;

  // Line input is asynchronous to the core clock
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= i_rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // Fixed-rate dividers for shift mode and 9-bit fixed mode
  always_comb
  begin
    m0_cnt_next = m0_cnt_reg + 8'h01;
    shift_tick_next = 1'b0;
    if (m0_cnt_reg == `SSP_MODE0_HALF_CYCLES - 8'h01)
    begin
      m0_cnt_next = 8'h00;
      shift_tick_next = 1'b1;
    end
    m2_cnt_next = m2_cnt_reg + 8'h01;
    m2_tick_next = 1'b0;
    if (m2_cnt_reg == `SSP_MODE2_TICK_CYCLES - 8'h01)
    begin
      m2_cnt_next = 8'h00;
      m2_tick_next = 1'b1;
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m0_cnt_reg <= 8'h00;
      m2_cnt_reg <= 8'h00;
      shift_tick_reg <= 1'b0;
      m2_tick_reg <= 1'b0;
    end
    else
    begin
      m0_cnt_reg <= m0_cnt_next;
      m2_cnt_reg <= m2_cnt_next;
      shift_tick_reg <= shift_tick_next;
      m2_tick_reg <= m2_tick_next;
    end
  end

  // Upper mode bit keeps its value while bit seven shows the error flag
  assign mode = ssp_pkg::ssp_mode_t'({ctrl_reg.mode_hi_or_frame_err,
                                      ctrl_reg.mode_lo_bit});
  assign m0 = (mode == ssp_pkg::SSP_MODE_SHIFT);
  // Variable rates come from a timer outside this block
  assign tick16 = (mode == ssp_pkg::SSP_MODE_FIXED9) ? m2_tick_reg
                                                     : i_baud_tick16;
  assign view = {i_flag_view_select ? fe_reg
                                    : ctrl_reg.mode_hi_or_frame_err,
                 ctrl_reg[`SSP_BIT_MODE_LO:0]};

  // Reception filter
  assign addr_match = (frame.data == i_given_addr) ||
                      (frame.data == i_bcast_addr);
  always_comb
  begin
    rx_accept = 1'b0;
    unique case (mode)
      ssp_pkg::SSP_MODE_SHIFT:
        rx_accept = frame.valid;
      ssp_pkg::SSP_MODE_UART8:
        rx_accept = frame.valid && (!ctrl_reg.multiproc_filter_en ||
                    (frame.stop && addr_match));
      ssp_pkg::SSP_MODE_FIXED9, ssp_pkg::SSP_MODE_VAR9:
        rx_accept = frame.valid && (!ctrl_reg.multiproc_filter_en ||
                    (frame.ninth && addr_match));
    endcase
  end
  assign frame_err = frame.valid && !m0 && !frame.stop;

  // Control register with hardware sets taking priority
  always_comb
  begin
    wmask = sfr_mask(i_sfr_req.addr, i_sfr_req.bit_op) &
            {8{i_sfr_req.wr}};
    wval = i_sfr_req.bit_op ? {8{i_sfr_req.wdata[0]}} : i_sfr_req.wdata;
    upd = (ctrl_reg & ~wmask) | (wval & wmask);
    ctrl_next = ssp_pkg::ssp_ctrl_t'(upd);
    fe_next = fe_reg;
    if (i_flag_view_select && wmask[`SSP_BIT_MODE_HI])
    begin
      ctrl_next.mode_hi_or_frame_err = ctrl_reg.mode_hi_or_frame_err;
      fe_next = wval[`SSP_BIT_MODE_HI];
    end
    if (frame_err)
      fe_next = 1'b1;
    if (tx_done)
      ctrl_next.tx_done_flag = 1'b1;
    if (rx_accept)
    begin
      ctrl_next.rx_done_flag = 1'b1;
      if (!m0)
        ctrl_next.ninth_rx_bit = frame.ninth;
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `SSP_CTRL_RESET;
      fe_reg <= `SSP_FE_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      fe_reg <= fe_next;
    end
  end

  // Engines
  assign tx_start = i_tx_load && !tx_busy;
  // Shift mode shares one clock pin, so transmit holds off reception
  assign shift_start = ctrl_reg.rx_enable && !ctrl_reg.rx_done_flag &&
                       !frame.valid && !tx_busy;
  ssp_tx u_tx (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_mode(mode),
    .i_tick16(tick16),
    .i_shift_tick(shift_tick_reg),
    .i_start(tx_start),
    .i_data(i_tx_data),
    .i_ninth(ctrl_reg.ninth_tx_bit),
    .o_busy(tx_busy),
    .o_ser(tx_ser),
    .o_sclk(tx_sclk),
    .o_done(tx_done)
  );
  ssp_rx u_rx (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_mode(mode),
    .i_tick16(tick16),
    .i_shift_tick(shift_tick_reg),
    .i_enable(ctrl_reg.rx_enable),
    .i_shift_start(shift_start),
    .i_rxd(rxd_sync_reg),
    .o_frame(frame),
    .o_busy(rx_busy),
    .o_sclk(rx_sclk)
  );

  // Registered outputs
  always_comb
  begin
    rdata_next = rdata_reg;
    if (i_sfr_req.rd)
    begin
      if (i_sfr_req.bit_op)
        rdata_next = {7'h00, |(view & sfr_mask(i_sfr_req.addr, 1'b1))};
      else
        rdata_next = view & sfr_mask(i_sfr_req.addr, 1'b0);
    end
    rx_data_next = rx_accept ? frame.data : rx_data_reg;
    rx_valid_next = rx_accept;
    irq_next = i_port_int_en && (ctrl_next.tx_done_flag ||
               ctrl_next.rx_done_flag);
    if (m0)
      txd_next = tx_busy ? tx_sclk : (rx_busy ? rx_sclk : 1'b1);
    else
      txd_next = tx_ser;
    rxd_out_next = tx_ser;
    rxd_oe_next = m0 && tx_busy;
  end
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      irq_reg <= irq_next;
      txd_reg <= txd_next;
      rxd_out_reg <= rxd_out_next;
      rxd_oe_reg <= rxd_oe_next;
    end
  end
  assign o_sfr_rdata = rdata_reg;
  assign o_rx_data = rx_data_reg;
  assign o_rx_valid = rx_valid_reg;
  assign o_serial_irq = irq_reg;
  assign o_txd = txd_reg;
  assign o_rxd = rxd_out_reg;
  assign o_rxd_oe = rxd_oe_reg;
endmodule

/* ssp_port_assertions.sv */
// Assertion checker for the serial port control block
`timescale 1ns/1ps
module ssp_port_chk (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register access
  input wire ssp_pkg::ssp_sfr_req_t i_sfr_req,
  input wire logic [7:0] o_sfr_rdata,
  // Control and events
  input wire logic i_port_int_en,
  input wire logic i_tx_load,
  input wire logic o_rx_valid,
  // Pins
  input wire logic o_rxd_oe,
  input wire logic o_txd,
  input wire logic o_serial_irq
);
  logic [10:0] quiet_reg;
  logic [10:0] quiet_next;
  // Cycles since last load or write; saturates
  always_comb
  begin
    quiet_next = quiet_reg;
    if (i_tx_load || i_sfr_req.wr)
      quiet_next = 11'h000;
    else if (quiet_reg != 11'h7ff)
      quiet_next = quiet_reg + 11'h001;
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      quiet_reg <= 11'h000;
    else
      quiet_reg <= quiet_next;
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  sequence no_write_s;
    !i_sfr_req.wr;
  endsequence
  sequence irq_live_s;
    o_serial_irq && i_port_int_en;
  endsequence
  irq_off_a: assert property (!i_port_int_en |=> !o_serial_irq)
    else $error("irq while disabled");
  // A write in the live cycle may clear a flag, so it is excluded there
  irq_hold_a: assert property (irq_live_s ##0 no_write_s |=> o_serial_irq)
    else $error("flag dropped without write");
  rxv_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("rx valid longer than one cycle");
  rd_unmap_a: assert property (i_sfr_req.rd && !i_sfr_req.bit_op &&
    i_sfr_req.addr != 8'hf8 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  bit_rd_a: assert property (i_sfr_req.rd && i_sfr_req.bit_op
    |=> o_sfr_rdata[7:1] == 7'h00)
    else $error("bit read upper bits set");
  rdata_hold_a: assert property (!i_sfr_req.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without read");
  // Longest frame is well under 1000 cycles
  txd_idle_a: assert property (quiet_reg > 11'h3e8 |-> o_txd)
    else $error("txd active with nothing pending");
  oe_idle_a: assert property (quiet_reg > 11'h3e8 |-> !o_rxd_oe)
    else $error("rxd driven with nothing pending");
endmodule
bind ssp_port ssp_port_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_sfr_req(i_sfr_req), .o_sfr_rdata(o_sfr_rdata),
  .i_port_int_en(i_port_int_en), .i_tx_load(i_tx_load),
  .o_rx_valid(o_rx_valid), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd),
  .o_serial_irq(o_serial_irq));

/* ssp_far_node.sv */
// Behavioural far-end serial node for the serial port bench
`timescale 1ns/1ps
module ssp_far_node #(
  parameter int BIT_CYC = 64
) (
  // Clock
  input wire logic i_mclk,
  // Line from the block
  input wire logic i_line,
  // Line to the block, idles high
  output logic o_line
);
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine,
                      input logic b9, input logic stop);
    logic [10:0] f;
    f = {stop, b9, d, 1'b0};
    if (!nine)
      f[9] = stop;
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      o_line = f[i];
      repeat (BIT_CYC) @(negedge i_mclk);
    end
    o_line = 1'b1;
  endtask
  // Mid-bit sampling tolerates the tick phase offset
  task automatic grab(input logic nine, output logic [8:0] got,
                      output logic ok);
    got = 9'h000;
    ok = 1'b0;
    for (int k = 0; k < 4000 && i_line; k++)
      @(negedge i_mclk);
    if (!i_line)
    begin
      repeat (BIT_CYC / 2) @(negedge i_mclk);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
        repeat (BIT_CYC) @(negedge i_mclk);
        got[i] = i_line;
      end
      repeat (BIT_CYC) @(negedge i_mclk);
      ok = i_line;
    end
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb_top;
  logic i_mclk;
  logic i_rst_n;
  ssp_pkg::ssp_sfr_req_t req;
  logic [7:0] rdata, tx_data, rx_data, v;
  logic view, int_en, tx_load, rx_valid;
  logic tick = 1'b0;
  logic far_rx, rxd_o, rxd_oe, txd, irq, ok, seen;
  logic [1:0] tdiv = 2'h0;
  logic [8:0] g;
  wire pin;
  int mismatches;
  int n_checks;
  // Shared RXD pin: block drives it only in shift mode
  assign pin = rxd_oe ? rxd_o : far_rx;
  ssp_port dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_req(req),
    .o_sfr_rdata(rdata), .i_flag_view_select(view),
    .i_port_int_en(int_en), .i_baud_tick16(tick),
    .i_given_addr(8'h33), .i_bcast_addr(8'hff), .i_tx_load(tx_load),
    .i_tx_data(tx_data), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .i_rxd(pin), .o_rxd(rxd_o), .o_rxd_oe(rxd_oe), .o_txd(txd),
    .o_serial_irq(irq));
  ssp_far_node far (.i_mclk(i_mclk), .i_line(txd), .o_line(far_rx));
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Sixteen-times tick every 4 cycles gives 64-cycle bits
  always @(negedge i_mclk)
  begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic b,
                     input logic [7:0] d);
    @(negedge i_mclk);
    req = {a, w, ~w, b, d};
    @(negedge i_mclk);
    req = '0;
    v = rdata;
  endtask
  task automatic wr(input logic [7:0] d);
    bus(8'hf8, 1'b1, 1'b0, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic b,
                        input logic [7:0] e);
    bus(a, 1'b0, b, 8'h00);
    chk(v, e);
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      @(negedge i_mclk);
      if (rx_valid === 1'b1)
        seen = 1'b1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_regs();
    rd_chk(8'hf8, 1'b0, 8'h00);
    wr(8'h78);
    rd_chk(8'hf8, 1'b0, 8'h78);
    bus(8'hfa, 1'b1, 1'b1, 8'h01);
    rd_chk(8'hf8, 1'b0, 8'h7c);
    rd_chk(8'hfe, 1'b1, 8'h01);
    rd_chk(8'hfb, 1'b1, 8'h01);
    rd_chk(8'hf9, 1'b0, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_tx(input logic [7:0] c, input logic n,
                      input logic [7:0] d);
    wr(c);
    tx_data = d;
    tx_load = 1'b1;
    @(negedge i_mclk);
    tx_load = 1'b0;
    far.grab(n, g, ok);
    if (!ok)
    begin
      mismatches++;
      report_and_stop();
    end
    chk(g[7:0], d);
    chk({7'h0, g[8]}, {7'h0, n & c[3]});
    rd_chk(8'hf9, 1'b1, 8'h01);
    chk({7'h0, irq}, 8'h01);
    // Stop bit must finish, a load while busy is dropped
    repeat (64) @(negedge i_mclk);
    $display("test tx done");
  endtask
  // Ninth-bit level is only defined for accepted frames
  task automatic t_rx(input logic [7:0] c, input logic [7:0] d,
                      input logic n, input logic b9, input logic st,
                      input logic acc, input logic r8);
    wr(c);
    fork
      far.send(d, n, b9, st);
      watch(900);
    join
    chk({7'h0, seen}, {7'h0, acc});
    rd_chk(8'hf8, 1'b1, {7'h0, acc});
    if (acc)
    begin
      chk(rx_data, d);
      rd_chk(8'hfa, 1'b1, {7'h0, r8});
    end
    $display("test rx done");
  endtask
  task automatic t_fe(input logic [7:0] e);
    view = 1'b1;
    rd_chk(8'hff, 1'b1, e);
    bus(8'hff, 1'b1, 1'b1, 8'h00);
    rd_chk(8'hff, 1'b1, 8'h00);
    view = 1'b0;
    $display("test frame error done");
  endtask
  // Shift mode: data on RXD pin, steady while the clock is low
  task automatic t_m0tx(input logic [7:0] d);
    wr(8'h08);
    tx_data = d;
    tx_load = 1'b1;
    @(negedge i_mclk);
    tx_load = 1'b0;
    g = 9'h000;
    for (int i = 0; i < 8; i++)
    begin
      for (int k = 0; k < 40 && txd; k++)
        @(negedge i_mclk);
      g[i] = rxd_o;
      if (i == 0)
        chk({7'h0, rxd_oe}, 8'h01);
      for (int k = 0; k < 40 && !txd; k++)
        @(negedge i_mclk);
    end
    chk(g[7:0], d);
    rd_chk(8'hf9, 1'b1, 8'h01);
    chk({7'h0, rxd_oe}, 8'h00);
    $display("test shift transmit done");
  endtask
  task automatic t_m0();
    wr(8'h30);
    watch(300);
    chk({7'h0, seen}, 8'h01);
    chk(rx_data, 8'hff);
    rd_chk(8'hf8, 1'b1, 8'h01);
    watch(300);
    chk({7'h0, seen}, 8'h00);
    int_en = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk({7'h0, irq}, 8'h00);
    int_en = 1'b1;
    $display("test shift mode done");
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    req = '0;
    view = 1'b0;
    int_en = 1'b1;
    tx_load = 1'b0;
    tx_data = 8'h00;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    t_regs();
    t_tx(8'h48, 1'b0, 8'ha5);
    t_tx(8'hc8, 1'b1, 8'h3c);
    t_tx(8'h80, 1'b1, 8'hc3);
    t_rx(8'h50, 8'h5a, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    t_fe(8'h00);
    t_rx(8'h50, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    t_fe(8'h01);
    t_rx(8'h70, 8'h11, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    t_rx(8'h70, 8'h33, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    t_rx(8'hf0, 8'h33, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    t_rx(8'hf0, 8'hff, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    t_rx(8'hd0, 8'h21, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    t_rx(8'hb0, 8'h33, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    t_rx(8'h40, 8'h12, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    t_m0();
    t_m0tx(8'h96);
    repeat (1100) @(negedge i_mclk);
    report_and_stop();
  end
endmodule
